// ---- copy_management_word_pkg.sv ----
// constants, register map and types of the copy-management line inserter
`default_nettype none
package copy_management_word_pkg;
  localparam logic [7:0] addr_enh_ctrl   = 8'h32;
  localparam logic [7:0] addr_data_0     = 8'h41;
  localparam logic [7:0] addr_data_1     = 8'h42;
  localparam logic [7:0] addr_data_2     = 8'h43;
  localparam logic [7:0] addr_pkt_ctrl   = 8'h5E;
  localparam logic [7:0] addr_pkt_last   = 8'h6E;
  localparam logic [7:0] addr_sd_ctrl    = 8'h99;
  localparam int         bit_enh_en      = 6;
  localparam int         bit_enh_crc     = 7;
  localparam int         bit_sd_crc      = 4;
  localparam int         bit_sd_field_lo = 5;
  localparam int         bit_pkt_en      = 0;
  localparam int         bit_pkt_crc     = 1;
  localparam logic [7:0] ctrl_reset      = 8'h00;
  localparam int         word_bits       = 20;
  localparam int         payload_bits    = 14;
  localparam int         pkt_bits        = 134;
  localparam int         pkt_payload     = 128;
  localparam int         pkt_regs        = 17;
  // packet bit 0 sits at bit 2 of the packet control register, above the two enables
  localparam int         pkt_hdr_lo      = 2;
  localparam logic [5:0] crc_preset      = 6'h3F;
  localparam logic [10:0] line_sd_odd    = 11'h014;
  localparam logic [10:0] line_sd_even   = 11'h11B;
  localparam logic [10:0] line_525_word  = 11'h029;
  localparam logic [10:0] line_525_pkt   = 11'h028;
  localparam logic [10:0] line_625_word  = 11'h02B;
  localparam logic [10:0] line_720_word  = 11'h018;
  localparam logic [10:0] line_720_pkt   = 11'h017;
  localparam logic [10:0] line_1080_w0   = 11'h013;
  localparam logic [10:0] line_1080_w1   = 11'h246;
  localparam logic [10:0] line_1080_p0   = 11'h012;
  localparam logic [10:0] line_1080_p1   = 11'h245;
  typedef enum logic [2:0] {
    fmt_ntsc  = 3'b000,
    fmt_pal   = 3'b001,
    fmt_525p  = 3'b010,
    fmt_625p  = 3'b011,
    fmt_720p  = 3'b100,
    fmt_1080i = 3'b101
  } format_type;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_ref   = 2'b01,
    st_shift = 2'b10
  } state_type;
endpackage : copy_management_word_pkg
`default_nettype wire

// ---- copy_management_word_fifo.sv ----
// small valid/ready fifo holding serialised bits before the output path
`default_nettype none
module copy_management_word_fifo #(
  parameter int width = 2,
  parameter int depth = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [width-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [width-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int aw = $clog2(depth);
  if (depth < 2 || (1 << aw) != depth) begin : g_depth_check
    $error("depth must be a power of two");
  end
  logic [width-1:0] mem [depth];
  logic [aw:0]      wr_ptr;
  logic [aw:0]      rd_ptr;
  logic [aw:0]      next_wr_ptr;
  logic [aw:0]      next_rd_ptr;
  logic             push;
  logic             pop;
  always_comb begin
    in_ready    = (wr_ptr - rd_ptr) != (aw+1)'(depth);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[aw-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[aw-1:0]] <= in_data;
    end
  end
endmodule : copy_management_word_fifo
`default_nettype wire

// ---- copy_management_word_vbi_inserter.sv ----
// copy-management word and packet inserter for blanking lines
`default_nettype none
module copy_management_word_vbi_inserter
  import copy_management_word_pkg::*;
#(
  parameter int fifo_depth = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic [7:0]            reg_rdata,
  input  wire copy_management_word_pkg::format_type video_format,
  input  wire logic             line_start,
  input  wire logic [10:0]      line_number,
  input  wire logic             odd_field,
  output logic                  bit_valid,
  output logic                  bit_value,
  output logic                  bit_is_ref,
  input  wire logic             bit_ready,
  output logic                  insert_busy
);
  import copy_management_word_pkg::*;
  if (fifo_depth < 2) begin : g_depth_check
    $error("fifo_depth too small");
  end
  // ==========================================================
  // registers
  logic [7:0] enh_ctrl;
  logic [7:0] sd_ctrl;
  logic [7:0] data_reg [3];
  logic [7:0] pkt_reg [pkt_regs];
  logic [7:0] next_enh_ctrl;
  logic [7:0] next_sd_ctrl;
  logic [7:0] next_data_reg [3];
  logic [7:0] next_pkt_reg [pkt_regs];
  logic [7:0] next_reg_rdata;
  logic [7:0] pkt_idx;
  always_comb begin
    next_enh_ctrl = enh_ctrl;
    next_sd_ctrl  = sd_ctrl;
    next_data_reg = data_reg;
    next_pkt_reg  = pkt_reg;
    pkt_idx       = reg_addr - addr_pkt_ctrl;
    if (reg_wr) begin
      if (reg_addr == addr_enh_ctrl) begin
        next_enh_ctrl = reg_wdata;
      end else if (reg_addr == addr_sd_ctrl) begin
        next_sd_ctrl = reg_wdata;
      end else if (reg_addr >= addr_data_0 && reg_addr <= addr_data_2) begin
        next_data_reg[2'(reg_addr - addr_data_0)] = reg_wdata;
      end else if (reg_addr >= addr_pkt_ctrl && reg_addr <= addr_pkt_last) begin
        next_pkt_reg[5'(pkt_idx)] = reg_wdata;
      end
    end
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      if (reg_addr == addr_enh_ctrl) begin
        next_reg_rdata = enh_ctrl;
      end else if (reg_addr == addr_sd_ctrl) begin
        next_reg_rdata = sd_ctrl;
      end else if (reg_addr >= addr_data_0 && reg_addr <= addr_data_2) begin
        next_reg_rdata = data_reg[2'(reg_addr - addr_data_0)];
      end else if (reg_addr >= addr_pkt_ctrl && reg_addr <= addr_pkt_last) begin
        next_reg_rdata = pkt_reg[5'(pkt_idx)];
      end else begin
        next_reg_rdata = 8'h00;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      enh_ctrl  <= ctrl_reset;
      sd_ctrl   <= ctrl_reset;
      data_reg  <= '{default: ctrl_reset};
      pkt_reg   <= '{default: ctrl_reset};
      reg_rdata <= 8'h00;
    end else begin
      enh_ctrl  <= next_enh_ctrl;
      sd_ctrl   <= next_sd_ctrl;
      data_reg  <= next_data_reg;
      pkt_reg   <= next_pkt_reg;
      reg_rdata <= next_reg_rdata;
    end
  end
  // ==========================================================
  // check sequence
  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic d);
    logic fb;
    fb = c[5] ^ d;
    crc_step = {c[4:1], c[0] ^ fb, fb};
  endfunction : crc_step
  logic [19:0]        word_raw;
  logic [19:0]        word_out;
  logic [pkt_regs*8-1:0] pkt_flat;
  logic [pkt_bits-1:0] pkt_out;
  logic [5:0]         word_crc;
  logic [5:0]         pkt_crc;
  always_comb begin
    // word from the three data registers, low bits first
    word_raw = {data_reg[2][3:0], data_reg[1], data_reg[0]};
    // 625p keeps only the upper two registers
    if (video_format == fmt_625p) begin
      word_raw[7:0] = 8'h00;
    end
    pkt_flat = '0;
    for (int i = 0; i < pkt_regs; i++) begin
      pkt_flat[i*8 +: 8] = pkt_reg[i];
    end
    // preset all ones before each run
    word_crc = crc_preset;
    for (int i = 0; i < payload_bits; i++) begin
      word_crc = crc_step(word_crc, word_raw[i]);
    end
    pkt_crc = crc_preset;
    for (int i = 0; i < pkt_payload; i++) begin
      pkt_crc = crc_step(pkt_crc, pkt_flat[pkt_hdr_lo + i]);
    end
    word_out = word_raw;
    if ((video_format == fmt_ntsc) ? sd_ctrl[bit_sd_crc] : enh_ctrl[bit_enh_crc]) begin
      word_out[19:14] = word_crc;
    end
    // packet check or stored bits
    // header bits live above the enables, so the packet fills the register span exactly
    pkt_out = pkt_flat[pkt_hdr_lo +: pkt_bits];
    if (pkt_reg[0][bit_pkt_crc]) begin
      pkt_out[pkt_bits-1 -: 6] = pkt_crc;
    end
  end
  // ==========================================================
  // line plan
  logic send_word;
  logic send_pkt;
  always_comb begin
    send_word = 1'b0;
    send_pkt  = 1'b0;
    // one format plan at a time
    case (video_format)
      fmt_ntsc: begin
        send_word = (odd_field && sd_ctrl[bit_sd_field_lo] && line_number == line_sd_odd)
                 || (!odd_field && sd_ctrl[bit_sd_field_lo+1] && line_number == line_sd_even);
      end
      fmt_525p: begin
        send_word = enh_ctrl[bit_enh_en] && line_number == line_525_word;
        send_pkt  = pkt_reg[0][bit_pkt_en] && line_number == line_525_pkt;
      end
      fmt_625p: begin
        send_word = enh_ctrl[bit_enh_en] && line_number == line_625_word;
      end
      fmt_720p: begin
        send_word = enh_ctrl[bit_enh_en] && line_number == line_720_word;
        send_pkt  = pkt_reg[0][bit_pkt_en] && line_number == line_720_pkt;
      end
      fmt_1080i: begin
        send_word = enh_ctrl[bit_enh_en]
                 && (line_number == line_1080_w0 || line_number == line_1080_w1);
        send_pkt  = pkt_reg[0][bit_pkt_en]
                 && (line_number == line_1080_p0 || line_number == line_1080_p1);
      end
      default: begin
        send_word = 1'b0;
      end
    endcase
  end
  // ==========================================================
  // serialiser
  state_type            state;
  state_type            next_state;
  logic [pkt_bits-1:0]  shreg;
  logic [pkt_bits-1:0]  next_shreg;
  logic [7:0]           remain;
  logic [7:0]           next_remain;
  logic [1:0]           push_data;
  logic                 push_valid;
  logic                 push_ready;
  logic [1:0]           pop_data;
  logic                 pop_valid;
  always_comb begin
    next_state  = state;
    next_shreg  = shreg;
    next_remain = remain;
    push_data   = {1'b0, shreg[0]};
    push_valid  = 1'b0;
    case (state)
      st_idle: begin
        if (line_start && send_pkt) begin
          next_shreg  = pkt_out;
          next_remain = 8'(pkt_bits);
          next_state  = st_shift;
        end else if (line_start && send_word) begin
          next_shreg  = {{(pkt_bits-word_bits){1'b0}}, word_out};
          next_remain = 8'(word_bits);
          // reference pulse only in standard definition
          next_state  = (video_format == fmt_ntsc) ? st_ref : st_shift;
        end
      end
      st_ref: begin
        push_data  = 2'b11;
        push_valid = 1'b1;
        if (push_ready) begin
          next_state = st_shift;
        end
      end
      st_shift: begin
        push_valid = 1'b1;
        if (push_ready) begin
          next_shreg  = shreg >> 1;
          next_remain = remain - 8'h01;
          if (remain == 8'h01) begin
            next_state = st_idle;
          end
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      state  <= st_idle;
      shreg  <= '0;
      remain <= 8'h00;
    end else begin
      state  <= next_state;
      shreg  <= next_shreg;
      remain <= next_remain;
    end
  end
  copy_management_word_fifo #(
    .width (2),
    .depth (fifo_depth)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (pop_data),
    .out_valid (pop_valid),
    .out_ready (bit_ready || !bit_valid)
  );
  // ==========================================================
  // output stage
  logic next_bit_valid;
  logic next_bit_value;
  logic next_bit_is_ref;
  logic next_busy;
  always_comb begin
    next_bit_valid  = bit_valid;
    next_bit_value  = bit_value;
    next_bit_is_ref = bit_is_ref;
    if (bit_ready || !bit_valid) begin
      next_bit_valid  = pop_valid;
      next_bit_value  = pop_data[0];
      next_bit_is_ref = pop_data[1];
    end
    next_busy = (next_state != st_idle) || pop_valid || next_bit_valid;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      bit_valid   <= 1'b0;
      bit_value   <= 1'b0;
      bit_is_ref  <= 1'b0;
      insert_busy <= 1'b0;
    end else begin
      bit_valid   <= next_bit_valid;
      bit_value   <= next_bit_value;
      bit_is_ref  <= next_bit_is_ref;
      insert_busy <= next_busy;
    end
  end
endmodule : copy_management_word_vbi_inserter
`default_nettype wire

// ---- copy_management_word_bit_sink.sv ----
// consumer model of the timing and display path taking the inserted bits
`default_nettype none
module copy_management_word_bit_sink (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic bit_valid,
  input  wire logic bit_value,
  input  wire logic bit_is_ref,
  output logic      bit_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // each entry is {reference flag, level}
  logic [1:0] got[$];
  initial begin
    bit_ready = 1'b0;
  end
  // a stalling consumer takes a bit only every other cycle
  always @(posedge clk) begin
    if (bit_valid && bit_ready) begin
      got.push_back({bit_is_ref, bit_value});
    end
    bit_ready <= stall ? ~bit_ready : 1'b1;
  end
endmodule : copy_management_word_bit_sink
`default_nettype wire

// ---- copy_management_word_vbi_inserter_checker.sv ----
// port assertions of the copy-management line inserter
`default_nettype none
module copy_management_word_vbi_inserter_checker
  import copy_management_word_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 reg_wr,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire copy_management_word_pkg::format_type video_format,
  input wire logic                 line_start,
  input wire logic [10:0]          line_number,
  input wire logic                 odd_field,
  input wire logic                 bit_valid,
  input wire logic                 bit_value,
  input wire logic                 bit_is_ref,
  input wire logic                 bit_ready,
  input wire logic                 insert_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] sd;
  logic [7:0] n;
  logic       go;
  assign go = line_start && !insert_busy;
  // shadow of the sd control and count of bits taken since the line began
  always_ff @(posedge clk) begin
    if (srst) sd <= 8'h00;
    else if (reg_wr && reg_addr == 8'h99) sd <= reg_wdata;
    if (srst || go) n <= 8'h00;
    else if (bit_valid && bit_ready) n <= n + 8'h01;
  end
  a_sd_odd_line: assert property (go && video_format == fmt_ntsc && odd_field && sd[5]
    && line_number == 11'd20 |-> ##[2:4] (bit_valid && bit_is_ref))
    else $error("sd word missing on odd line 20");
  a_sd_even_off: assert property (go && video_format == fmt_ntsc && !odd_field && !sd[6]
    |=> !insert_busy [*4]) else $error("even field insertion while disabled");
  a_pal_quiet: assert property (go && video_format == fmt_pal |=> !insert_busy [*4])
    else $error("insertion in pal");
  a_ref_value: assert property (bit_valid && bit_is_ref |-> bit_value
    && video_format == fmt_ntsc) else $error("bad reference symbol");
  a_hold_bit: assert property (bit_valid && !bit_ready |=> bit_valid
    && $stable({bit_value, bit_is_ref})) else $error("bit changed while stalled");
  a_word_len: assert property ($fell(insert_busy) |-> (video_format == fmt_ntsc)
    ? n == 8'd21 : n inside {8'd20, 8'd134}) else $error("wrong bit count");
  a_busy_bits: assert property (bit_valid |-> insert_busy)
    else $error("bit without insertion");
  a_no_plan_line: assert property (go && line_number == 11'd21 |=> !insert_busy [*4])
    else $error("insertion on unplanned line");
  c_ntsc_ref: cover property (go && video_format == fmt_ntsc ##[2:4] bit_is_ref);
  c_packet: cover property ($fell(insert_busy) && n == 8'd134);
  c_stall: cover property (bit_valid && !bit_ready);
endmodule : copy_management_word_vbi_inserter_checker
bind copy_management_word_vbi_inserter copy_management_word_vbi_inserter_checker chk (.clk, .srst, .reg_wr, .reg_addr,
  .reg_wdata, .video_format, .line_start, .line_number, .odd_field, .bit_valid, .bit_value,
  .bit_is_ref, .bit_ready, .insert_busy);
`default_nettype wire

// ---- copy_management_word_vbi_inserter_tb_top.sv ----
// self-checking bench of the copy-management line inserter
`default_nettype none
module copy_management_word_vbi_inserter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import copy_management_word_pkg::*;
  logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, line_start = 0;
  logic        odd_field = 0, stall = 0, bit_valid, bit_value, bit_is_ref;
  logic        bit_ready, insert_busy;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [10:0] line_number = 0;
  format_type  video_format = fmt_ntsc;
  int          mismatches = 0, n_checks = 0, cycles = 0;
  logic [7:0]  d0 = 8'hA5, d1 = 8'h3C, d2 = 8'h59;
  logic [127:0] pv = {4{32'hC3A5_1E69}};
  always #50 clk = ~clk;
  copy_management_word_vbi_inserter dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .video_format, .line_start, .line_number, .odd_field, .bit_valid, .bit_value,
    .bit_is_ref, .bit_ready, .insert_busy);
  copy_management_word_bit_sink sink (.clk, .stall, .bit_valid, .bit_value, .bit_is_ref, .bit_ready);
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  function automatic logic [5:0] crc6(input logic [133:0] v, input int n);
    logic [5:0] c;
    logic       fb;
    c = 6'h3F;
    for (int i = 0; i < n; i++) begin
      fb = v[i] ^ c[5];
      c = {c[4:1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc6
  function automatic logic [133:0] exp_word(input logic crc, input logic z);
    logic [19:0] w;
    w = {d2[3:0], d1, d0};
    if (z) w[7:0] = 8'h00;
    if (crc) w[19:14] = crc6(134'(w[13:0]), 14);
    return 134'(w);
  endfunction : exp_word
  // packet: six header bits from the control register, then the sixteen data registers
  function automatic logic [133:0] exp_pkt(input logic crc);
    logic [133:0] p;
    p = {pv, 6'(8'hA4 >> 2)};
    if (crc) p[133:128] = crc6(134'(p[127:0]), 128);
    return p;
  endfunction : exp_pkt
  // one line start, then the received bits are judged; x bits are not compared
  task automatic line(input format_type f, input logic [10:0] ln, input logic odd,
                      input int n, input logic [133:0] e);
    int k;
    sink.got.delete();
    video_format <= f;
    line_number <= ln;
    odd_field <= odd;
    @(posedge clk);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    k = 0;
    repeat (4) @(posedge clk);
    while (insert_busy === 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (2) @(posedge clk);
    k = (f == fmt_ntsc && n > 0) ? 1 : 0;
    cmp("bit count", 16'(n + k), 16'(sink.got.size()));
    if (k == 1) cmp("reference", 16'h0003, 16'(sink.got[0]));
    for (int i = 0; i < n; i++)
      if (e[i] !== 1'bx) cmp("bit", 16'(e[i]), 16'(sink.got[i + k]));
  endtask : line
  task automatic t_regs();
    logic [7:0] a[7] = '{8'h32, 8'h41, 8'h42, 8'h43, 8'h5E, 8'h6E, 8'h99};
    foreach (a[i]) begin
      rd(a[i]);
      cmp("reset value", 16'h0000, 16'(reg_rdata));
      wr(a[i], 8'h5A ^ 8'(i));
      rd(a[i]);
      cmp("readback", 16'(8'h5A ^ 8'(i)), 16'(reg_rdata));
      wr(a[i], 8'h00);
    end
    wr(8'h50, 8'hFF);
    rd(8'h50);
    cmp("unmapped", 16'h0000, 16'(reg_rdata));
  endtask : t_regs
  task automatic t_sd();
    wr(8'h41, d0);
    wr(8'h42, d1);
    wr(8'h43, d2);
    wr(8'h99, 8'h20);
    line(fmt_ntsc, 11'd20, 1'b1, 20, exp_word(1'b0, 1'b0));
    line(fmt_ntsc, 11'd283, 1'b0, 0, '0);
    wr(8'h99, 8'h40);
    line(fmt_ntsc, 11'd283, 1'b0, 20, exp_word(1'b0, 1'b0));
    line(fmt_ntsc, 11'd20, 1'b1, 0, '0);
    wr(8'h99, 8'h70);
    line(fmt_ntsc, 11'd20, 1'b1, 20, exp_word(1'b1, 1'b0));
    line(fmt_ntsc, 11'd283, 1'b0, 20, exp_word(1'b1, 1'b0));
    line(fmt_pal, 11'd20, 1'b1, 0, '0);
    line(fmt_ntsc, 11'd21, 1'b1, 0, '0);
    wr(8'h99, 8'h00);
  endtask : t_sd
  task automatic t_hd();
    format_type f[6] = '{fmt_525p, fmt_625p, fmt_720p, fmt_1080i, fmt_1080i, fmt_720p};
    logic [10:0] l[6] = '{11'd41, 11'd43, 11'd24, 11'd19, 11'd582, 11'd41};
    logic [7:0] c[3] = '{8'h00, 8'h40, 8'hC0};
    stall <= 1'b1;
    foreach (c[j]) begin
      wr(8'h32, c[j]);
      foreach (f[i])
        line(f[i], l[i], i != 4, (c[j][6] && i < 5) ? 20 : 0,
             exp_word(c[j][7], f[i] == fmt_625p));
    end
    wr(8'h32, 8'h00);
  endtask : t_hd
  task automatic t_pkt();
    format_type f[5] = '{fmt_525p, fmt_720p, fmt_1080i, fmt_1080i, fmt_625p};
    logic [10:0] l[5] = '{11'd40, 11'd23, 11'd18, 11'd581, 11'd40};
    for (int i = 0; i < 16; i++)
      wr(8'h5F + 8'(i), pv[i*8 +: 8]);
    for (int j = 1; j < 4; j += 2) begin
      wr(8'h5E, 8'hA4 | 8'(j));
      foreach (f[i])
        line(f[i], l[i], i != 3, (i < 4) ? 134 : 0,
             exp_pkt(j == 3));
    end
  endtask : t_pkt
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sd();
    t_hd();
    t_pkt();
    end_of_test();
  end
endmodule : copy_management_word_vbi_inserter_tb_top
`default_nettype wire
